/* spi_port_consts.vh */
// constants for the synchronous serial port in its spi role
// assumes inclusion by bare name from the port's design files
`ifndef SPI_PORT_CONSTS_VH
`define SPI_PORT_CONSTS_VH

`define CTL_MODE_LSB      0
`define CTL_MODE_MSB      3
`define CTL_CKP_BIT       4
`define CTL_EN_BIT        5
`define CTL_WRITE_COLLISION_FLAG_BIT      7
`define STAT_SMP_BIT      7
`define STAT_CKE_BIT      6
`define STAT_BF_BIT       0

`define MODE_MASTER_DIV4  4'h0
`define MODE_MASTER_DIV16 4'h1
`define MODE_MASTER_DIV64 4'h2
`define MODE_MASTER_TMR2  4'h3
`define MODE_SLAVE_SS     4'h4
`define MODE_SLAVE_NOSS   4'h5
`define MODE_MASTER_BRG   4'hA

`define CTL_ONE_RESET     8'h00
`define STAT_RESET        8'h00
`define BITS_PER_BYTE     4'h8
`define HALF_DIV4         10'h002
`define HALF_DIV16        10'h008
`define HALF_DIV64        10'h020
`define BRG_HALF_BASE     10'h002

`endif

/* spi_rate_gen.v */
// serial clock tick generator for master role
// assumes tmr2_tick is a one-cycle pulse from the timer block
`timescale 1ns/1ps
`include "spi_port_consts.vh"

module spi_rate_gen (
  input  wire       clk,
  input  wire       reset,
  input  wire [3:0] mode,
  input  wire [7:0] reload,
  input  wire       tmr2_tick,
  input  wire       run,
  output reg        half_tick
);
  // each half_tick marks one serial clock half period; full period = 2 half periods
  reg  [8:0] count;
  reg  [9:0] half_len;

  always @* begin
    case (mode)
      `MODE_MASTER_DIV4:  half_len = `HALF_DIV4;
      `MODE_MASTER_DIV16: half_len = `HALF_DIV16;
      `MODE_MASTER_DIV64: half_len = `HALF_DIV64;
      // tenth bit keeps a reload of all ones from wrapping to zero
      `MODE_MASTER_BRG:   half_len = {1'b0, reload, 1'b0} + `BRG_HALF_BASE;
      default:            half_len = 10'h001;
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      count     <= 9'h000;
      half_tick <= 1'b0;
    end else if (!run) begin
      count     <= 9'h000;
      half_tick <= 1'b0;
    end else if (mode == `MODE_MASTER_TMR2) begin
      half_tick <= tmr2_tick;
    end else if ({1'b0, count} + 10'h001 >= half_len) begin
      count     <= 9'h000;
      half_tick <= 1'b1;
    end else begin
      count     <= count + 9'h001;
      half_tick <= 1'b0;
    end
  end
endmodule // spi_rate_gen

/* spi_serial_port.v */
// spi role of the synchronous serial port: shift register, data buffer, flags
// assumes pin inputs synchronous to REF_CLK; registers reached as plain ports
`timescale 1ns/1ps
`include "spi_port_consts.vh"

// Summary of operation
// - eight-bit shifter, msb out, lsb in
// - drive on one edge, sample on other
// - data out feeds partner data in; slave mode 0101 keeps DATA_OUT_OE low
// - eight clocks exchange both bytes
// - same polarity; master starts the clock
// - master selects one slave at once
// - deselected slave ignores lines, drives nothing
// - master stops clock then deselects
// - full byte copies to buffer, flags set
// - buffer write loads shifter too
// - shifter reached only through data buffer
// - next byte shifts before buffer read
// - write while shifting dropped, collision set
// - buffer read clears buffer-full flag
// - control bits choose role, edges, rate
// - master drives clock, slave receives it
// - enable bit gates port; reconfigure disabled
// - status low six read-only
// - reload register sets generator rate
// - master rates div4/16/64/timer/reload
// - master write starts shifting at once
// - mode 0100 is slave with select
// - select high floats output, resets count
module spi_serial_port (
  input  wire       REF_CLK,
  input  wire       RESET,
  input  wire [7:0] CTL_ONE_WDATA,
  input  wire       CTL_ONE_WE,
  output wire [7:0] CTL_ONE_RDATA,
  input  wire [7:0] STATUS_WDATA,
  input  wire       STATUS_WE,
  output wire [7:0] STATUS_RDATA,
  input  wire [7:0] RELOAD_WDATA,
  input  wire       RELOAD_WE,
  output wire [7:0] RELOAD_RDATA,
  input  wire [7:0] BUF_WDATA,
  input  wire       BUF_WE,
  input  wire       BUF_RE,
  output wire [7:0] BUF_RDATA,
  input  wire       IRQ_CLR,
  output reg        IRQ_FLAG,
  input  wire       TMR2_TICK,
  input  wire       SCK_IN,
  output reg        SCK_OUT,
  output wire       SCK_OE,
  input  wire       DATA_IN_PIN,
  output reg        DATA_OUT_PIN,
  output wire       DATA_OUT_OE,
  input  wire       SS_N
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_LEAD  = 3'b010;
  localparam ST_TRAIL = 3'b100;

  reg  [7:0] ctl_one;
  reg  [1:0] stat_hi;
  reg  [7:0] reload;
  reg  [7:0] data_buffer;
  reg  [7:0] shift_register;
  reg  [3:0] bit_count;
  reg        buffer_full_flag;
  reg        write_collision_flag;
  reg  [2:0] state;
  reg        sck_prev;
  reg        sample_bit;
  reg        late_pending;

  wire [3:0] mode      = ctl_one[`CTL_MODE_MSB:`CTL_MODE_LSB];
  wire       clock_polarity_bit       = ctl_one[`CTL_CKP_BIT];
  wire       enabled   = ctl_one[`CTL_EN_BIT];
  wire       cke       = stat_hi[0];
  wire       sample_phase_bit       = stat_hi[1];
  wire       is_slave  = (mode == `MODE_SLAVE_SS) || (mode == `MODE_SLAVE_NOSS);
  wire       use_ss    = (mode == `MODE_SLAVE_SS);
  wire       selected  = !use_ss || !SS_N;
  wire       busy      = (bit_count != 4'h0) || (state != ST_IDLE);
  wire       half_tick;

  // active edge of the slave clock: leading edge leaves idle level
  wire sck_rise    = SCK_IN && !sck_prev;
  wire sck_fall    = !SCK_IN && sck_prev;
  wire sck_leading = clock_polarity_bit ? sck_fall : sck_rise;
  wire sck_trail   = clock_polarity_bit ? sck_rise : sck_fall;

  wire buf_write_ok = BUF_WE && enabled && !busy && !write_collision_flag;
  wire byte_done;
  reg  [7:0] next_shift;
  reg  [3:0] next_count;
  reg  [2:0] next_state;
  reg        do_sample;
  reg        do_drive;

  assign CTL_ONE_RDATA = {write_collision_flag, ctl_one[6:0]};
  assign STATUS_RDATA  = {stat_hi, 5'h00, buffer_full_flag};
  assign RELOAD_RDATA  = reload;
  assign BUF_RDATA     = data_buffer;
  assign SCK_OE        = enabled && !is_slave;
  assign DATA_OUT_OE   = enabled && (!is_slave || (use_ss && !SS_N));

  spi_rate_gen u_rate (
    .clk       (REF_CLK),
    .reset     (RESET),
    .mode      (mode),
    .reload    (reload),
    .tmr2_tick (TMR2_TICK),
    .run       (enabled && !is_slave && state != ST_IDLE),
    .half_tick (half_tick)
  );

  // sequencing of edges: master walks states on half ticks, slave on pin edges
  always @* begin
    next_state = state;
    do_sample  = 1'b0;
    do_drive   = 1'b0;
    if (!is_slave) begin
      case (state)
        ST_IDLE:  next_state = ST_IDLE;
        ST_LEAD: begin
          if (half_tick) begin
            next_state = ST_TRAIL;
            do_sample  = cke;
            do_drive   = !cke;
          end
        end
        ST_TRAIL: begin
          if (half_tick) begin
            do_sample  = !cke;
            do_drive   = cke;
            next_state = (bit_count == `BITS_PER_BYTE - 4'h1) ? ST_IDLE : ST_LEAD;
          end
        end
        default:  next_state = ST_IDLE;
      endcase
    end else if (selected) begin
      do_sample = cke ? sck_leading : sck_trail;
      do_drive  = cke ? sck_trail : sck_leading;
    end
  end

  // count advances on the master's trailing half tick and on the slave's sample edge
  assign byte_done = (bit_count == `BITS_PER_BYTE - 4'h1) &&
                     (is_slave ? (cke ? sck_leading : sck_trail) : (state == ST_TRAIL && half_tick))
                     && selected;

  always @* begin
    next_shift = shift_register;
    next_count = bit_count;
    if (do_sample) begin
      // smp=1 in master holds the sample to the end of the bit
      if (!(sample_phase_bit && !is_slave))
        next_shift = {shift_register[6:0], DATA_IN_PIN};
    end
    if (late_pending && do_drive)
      next_shift = {shift_register[6:0], sample_bit};
    if ((is_slave && (cke ? sck_leading : sck_trail) && selected) ||
        (!is_slave && state == ST_TRAIL && half_tick))
      next_count = (bit_count == `BITS_PER_BYTE - 4'h1) ? 4'h0 : bit_count + 4'h1;
  end

  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      ctl_one              <= `CTL_ONE_RESET;
      stat_hi              <= 2'b00;
      reload               <= 8'h00;
      data_buffer          <= 8'h00;
      shift_register       <= 8'h00;
      bit_count            <= 4'h0;
      buffer_full_flag     <= 1'b0;
      write_collision_flag <= 1'b0;
      IRQ_FLAG             <= 1'b0;
      state                <= ST_IDLE;
      sck_prev             <= 1'b0;
      sample_bit           <= 1'b0;
      late_pending         <= 1'b0;
      SCK_OUT              <= 1'b0;
      DATA_OUT_PIN         <= 1'b0;
    end else begin
      sck_prev <= SCK_IN;
      if (CTL_ONE_WE)
        ctl_one <= {1'b0, CTL_ONE_WDATA[6:0]};
      if (STATUS_WE)
        stat_hi <= STATUS_WDATA[7:6];
      if (RELOAD_WE)
        reload <= RELOAD_WDATA;

      // collision: set wins over software clear
      if (BUF_WE && enabled && busy)
        write_collision_flag <= 1'b1;
      else if (CTL_ONE_WE && !CTL_ONE_WDATA[`CTL_WRITE_COLLISION_FLAG_BIT])
        write_collision_flag <= 1'b0;

      if (!enabled || (use_ss && SS_N)) begin
        // disable or deselect resets the bit counter mid-byte
        bit_count    <= 4'h0;
        state        <= ST_IDLE;
        late_pending <= 1'b0;
        SCK_OUT      <= clock_polarity_bit;
        if (buf_write_ok || (BUF_WE && !enabled)) begin
          data_buffer    <= BUF_WDATA;
          shift_register <= BUF_WDATA;
          // msb must already stand when select falls
          DATA_OUT_PIN   <= BUF_WDATA[7];
        end
      end else begin
        state     <= next_state;
        bit_count <= next_count;
        if (buf_write_ok) begin
          data_buffer    <= BUF_WDATA;
          shift_register <= BUF_WDATA;
          DATA_OUT_PIN   <= BUF_WDATA[7];
          if (!is_slave)
            state <= ST_LEAD;
        end else begin
          shift_register <= next_shift;
          if (do_drive)
            DATA_OUT_PIN <= next_shift[7];
        end
        if (do_sample && sample_phase_bit && !is_slave) begin
          sample_bit   <= DATA_IN_PIN;
          late_pending <= 1'b1;
        end else if (late_pending && do_drive) begin
          late_pending <= 1'b0;
        end
        if (!is_slave) begin
          if (state == ST_IDLE && !buf_write_ok)
            SCK_OUT <= clock_polarity_bit;
          else if (half_tick && state != ST_IDLE)
            SCK_OUT <= (state == ST_LEAD) ? !clock_polarity_bit : clock_polarity_bit;
        end
        if (byte_done) begin
          // with cke set the late path has already shifted the last bit in
          data_buffer  <= (sample_phase_bit && !is_slave && !cke) ? {next_shift[6:0], DATA_IN_PIN} : next_shift;
          late_pending <= 1'b0;
        end
      end

      // flags set with the copy; set wins over clear
      if (byte_done && enabled && !(use_ss && SS_N))
        buffer_full_flag <= 1'b1;
      else if (BUF_RE)
        buffer_full_flag <= 1'b0;
      if (byte_done && enabled && !(use_ss && SS_N))
        IRQ_FLAG <= 1'b1;
      else if (IRQ_CLR)
        IRQ_FLAG <= 1'b0;
    end
  end
endmodule // spi_serial_port

/* spi_serial_port_properties.sv */
// assertions on the spi port registers and pins
// assumes binding onto spi_serial_port
`timescale 1ns/1ps
module spi_port_checker (
  input wire       REF_CLK,
  input wire       RESET,
  input wire [7:0] CTL_ONE_WDATA,
  input wire       CTL_ONE_WE,
  input wire [7:0] CTL_ONE_RDATA,
  input wire [7:0] STATUS_WDATA,
  input wire       STATUS_WE,
  input wire [7:0] STATUS_RDATA,
  input wire       BUF_WE,
  input wire       BUF_RE,
  input wire       IRQ_FLAG,
  input wire       SCK_OUT,
  input wire       SCK_OE,
  input wire       DATA_OUT_OE,
  input wire       SS_N
);
  wire       en  = CTL_ONE_RDATA[5];
  wire [3:0] md  = CTL_ONE_RDATA[3:0];
  wire       mst = en && md != 4'h4 && md != 4'h5;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // two samples allow a registered enable
  property p_ss_float; (en && md == 4'h4 && SS_N) [*2] |-> !DATA_OUT_OE; endproperty
  property p_off; (!en) [*2] |-> !SCK_OE && !DATA_OUT_OE; endproperty
  property p_sck_oe; $stable(CTL_ONE_RDATA) |-> SCK_OE == mst; endproperty
  property p_idle; mst && $rose(IRQ_FLAG) |-> ##2 SCK_OUT == CTL_ONE_RDATA[4]; endproperty
  property p_flags; $rose(STATUS_RDATA[0]) || $rose(IRQ_FLAG) |-> STATUS_RDATA[0] && IRQ_FLAG; endproperty
  property p_read_clr; BUF_RE |=> !STATUS_RDATA[0]; endproperty
  property p_write_collision_flag; $rose(CTL_ONE_RDATA[7]) |-> $past(BUF_WE); endproperty
  property p_stat; STATUS_WE |=> STATUS_RDATA[7:6] == $past(STATUS_WDATA[7:6]) && STATUS_RDATA[5:1] == 5'h00;
  endproperty
  property p_ctl; CTL_ONE_WE |=> CTL_ONE_RDATA[6:0] == $past(CTL_ONE_WDATA[6:0]); endproperty
  a_ss_float: assert property (p_ss_float) else $error("output driven while deselected");
  a_off: assert property (p_off) else $error("pins driven while disabled");
  a_sck_oe: assert property (p_sck_oe) else $error("clock direction wrong for role");
  a_idle: assert property (p_idle) else $error("clock not at idle level");
  a_flags: assert property (p_flags) else $error("flags not raised together");
  a_read_clr: assert property (p_read_clr) else $error("buffer read left full flag");
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision without buffer write");
  a_stat: assert property (p_stat) else $error("status readback wrong");
  a_ctl: assert property (p_ctl) else $error("control readback wrong");
  c_master: cover property (mst && $rose(IRQ_FLAG));
  c_slave: cover property (md == 4'h4 && $rose(IRQ_FLAG));
  c_write_collision_flag: cover property ($rose(CTL_ONE_RDATA[7]));
endmodule // spi_port_checker

bind spi_serial_port spi_port_checker u_chk (.REF_CLK(REF_CLK), .RESET(RESET),
  .CTL_ONE_WDATA(CTL_ONE_WDATA), .CTL_ONE_WE(CTL_ONE_WE), .CTL_ONE_RDATA(CTL_ONE_RDATA),
  .STATUS_WDATA(STATUS_WDATA), .STATUS_WE(STATUS_WE), .STATUS_RDATA(STATUS_RDATA),
  .BUF_WE(BUF_WE), .BUF_RE(BUF_RE), .IRQ_FLAG(IRQ_FLAG), .SCK_OUT(SCK_OUT),
  .SCK_OE(SCK_OE), .DATA_OUT_OE(DATA_OUT_OE), .SS_N(SS_N));

/* spi_slave_model.sv */
// behavioural spi slave facing the port in master role
// assumes sel_n stays low for a whole exchange
`timescale 1ns/1ps
module spi_slave_model (
  input  wire       sck,
  input  wire       clock_polarity_bit,
  input  wire       cke,
  input  wire       sel_n,
  input  wire       mosi,
  input  wire [7:0] tx,
  output reg        miso,
  output reg  [7:0] rx
);
  reg  [7:0] sr;
  wire       lead = (sck ^ clock_polarity_bit) & !sel_n;
  initial miso = 1'b0;
  always @(negedge sel_n) begin
    sr = tx;
    miso = tx[7];
  end
  // released line shows the inverse, never a held value
  always @(posedge sel_n) miso = !miso;
  // cke set: take on the leading edge, change on the trailing one
  always @(posedge lead) begin
    if (cke) begin
      sr = {sr[6:0], mosi};
      rx = sr;
    end else begin
      miso = sr[7];
    end
  end
  always @(negedge lead) begin
    if (!sel_n && cke) begin
      miso = sr[7];
    end else if (!sel_n) begin
      sr = {sr[6:0], mosi};
      rx = sr;
    end
  end
endmodule // spi_slave_model

/* test_spi_serial_port.sv */
// self-checking bench for the spi port in master and slave role
// assumes the slave model and the checker are compiled first
`timescale 1ns/1ps
module test_spi_serial_port;
  reg         clk = 1'b0, rst = 1'b1, sl = 1'b0, sel_n = 1'b1, tick = 1'b0;
  reg         sck_in = 1'b0, mo_bit = 1'b0, ss_n = 1'b1;
  reg  [5:0]  we = 6'h00;
  reg  [7:0]  wd = 8'h00, ptx = 8'h00, b, e;
  reg  [23:0] mt = 24'hA32100;
  reg  [3:0]  m;
  wire [7:0]  ctl_q, st_q, rl_q, bf_q, prx;
  wire        irq, sck, sck_oe, data_out_pin, sdo_oe, miso;
  wire        din = sl ? mo_bit : miso;
  integer     failures = 0, n_checks = 0, cyc = 0, i, k;
  spi_serial_port i_dut (.REF_CLK(clk), .RESET(rst), .CTL_ONE_WDATA(wd), .CTL_ONE_WE(we[0]),
    .CTL_ONE_RDATA(ctl_q), .STATUS_WDATA(wd), .STATUS_WE(we[1]), .STATUS_RDATA(st_q),
    .RELOAD_WDATA(wd), .RELOAD_WE(we[2]), .RELOAD_RDATA(rl_q), .BUF_WDATA(wd), .BUF_WE(we[3]),
    .BUF_RE(we[4]), .BUF_RDATA(bf_q), .IRQ_CLR(we[5]), .IRQ_FLAG(irq), .TMR2_TICK(tick),
    .SCK_IN(sck_in), .SCK_OUT(sck), .SCK_OE(sck_oe), .DATA_IN_PIN(din), .DATA_OUT_PIN(data_out_pin),
    .DATA_OUT_OE(sdo_oe), .SS_N(ss_n));
  spi_slave_model u_far (.sck(sck), .clock_polarity_bit(ctl_q[4]), .cke(st_q[6]), .sel_n(sel_n), .mosi(data_out_pin), .tx(ptx),
    .miso(miso), .rx(prx));
  always #2.5 clk = !clk;
  always @(posedge clk) begin
    tick <= ($urandom % 4) == 0;
    cyc = cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      finish_test;
    end
  end
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task finish_test;
    begin
      if (failures == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task settle;
    @(negedge clk);
  endtask
  task put(input integer n, input [7:0] d);
    begin
      @(posedge clk);
      wd <= d;
      we <= 6'h01 << n;
      @(posedge clk);
      we <= 6'h00;
    end
  endtask
  task xm(input [7:0] d, input [7:0] t, input col);
    begin
      ptx = t;
      sel_n <= 1'b0;
      put(3, d);
      if (col) begin
        put(3, ~d);
        settle;
        chk(ctl_q[7], 1);
      end
      k = 0;
      while (irq !== 1'b1 && k < 9000) begin
        @(posedge clk);
        k = k + 1;
      end
      settle;
      chk({st_q[0], bf_q}, {1'b1, t});
      chk(prx, d);
      put(4, 8'h00);
      put(5, 8'h00);
      settle;
      chk({st_q[0], irq}, 0);
      sel_n <= 1'b1;
    end
  endtask
  // bench is master: data set a half period before the leading edge
  task xs(input [7:0] d, input [7:0] t, input integer n);
    begin
      put(3, t);
      ss_n <= 1'b0;
      for (k = 0; k < n; k = k + 1) begin
        mo_bit <= d[7-k];
        repeat (4) @(posedge clk);
        chk({sdo_oe, irq, data_out_pin}, {m == 4'h4, 1'b0, t[7-k]});
        sck_in <= 1'b1;
        repeat (4) @(posedge clk);
        sck_in <= 1'b0;
      end
      repeat (4) @(posedge clk);
      ss_n <= 1'b1;
      mo_bit <= !mo_bit;
    end
  endtask
  initial begin
    i = $urandom(32'hD798);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    settle;
    chk({ctl_q, st_q}, 16'h0000);
    chk({sck_oe, sdo_oe, irq}, 0);
    put(1, 8'hFF);
    settle;
    chk(st_q, 8'hC0);
    for (i = 0; i < 6; i = i + 1) begin
      m = mt[4*i +: 4];
      put(0, 8'h00);
      // cke and smp vary only while the port is disabled
      put(1, {i > 2 && i[0], ~i[1], 6'h00});
      put(0, {3'h1, i[0], m});
      b = $urandom % 8;
      put(2, b);
      settle;
      chk({sck_oe, rl_q}, {1'b1, b});
      b = (i == 0) ? 8'h80 : $urandom;
      e = (i == 0) ? 8'h01 : $urandom;
      xm(b, e, i == 1);
    end
    put(0, 8'h00);
    put(1, 8'h40);
    put(0, 8'h24);
    sl <= 1'b1;
    m = 4'h4;
    settle;
    chk({sck_oe, sdo_oe}, 0);
    for (i = 0; i < 5; i = i + 1) begin
      b = $urandom;
      e = $urandom;
      if (i == 4) begin
        m = 4'h5;
        put(0, 8'h00);
        put(0, 8'h25);
      end
      if (i == 2) xs(~b, e, 3);
      xs(b, e, 8);
      settle;
      chk({irq, bf_q}, {1'b1, b});
      put(4, 8'h00);
      put(5, 8'h00);
    end
    finish_test;
  end
endmodule // test_spi_serial_port
